// File: core/sbn_pkg.sv
// Shared constants and types for the subtract-borrow / nibble-swap datapath
package sbn_pkg;
	localparam int SBN_DATA_W = 8;
	localparam int SBN_ADDR_W = 12;
	localparam int SBN_INSTR_W = 16;
	// Upper six opcode bits of the subtract-with-borrow word
	localparam logic [5:0] SBN_OPC_SUBB = 6'h16;
	// Upper six opcode bits of the nibble exchange word
	localparam logic [5:0] SBN_OPC_SWAP = 6'h0e;
	localparam int SBN_POS_DEST = 9;
	localparam int SBN_POS_BANK = 8;
	// Highest operand routed to indexed literal offset addressing
	localparam logic [7:0] SBN_IDX_LIMIT = 8'h5f;
	// Access bank split: f below 60h in bank 0, 60h and above in bank 15
	localparam logic [7:0] SBN_ACC_SPLIT = 8'h60;
	localparam logic [3:0] SBN_ACC_HI_BANK = 4'hf;
	localparam int SBN_FLG_C = 0;
	localparam int SBN_FLG_DC = 1;
	localparam int SBN_FLG_Z = 2;
	localparam int SBN_FLG_OV = 3;
	localparam int SBN_FLG_N = 4;
	localparam logic [7:0] SBN_ACC_RST = 8'h00;
	localparam logic [4:0] SBN_FLG_RST = 5'h00;
	typedef enum logic [1:0] {
		SBN_Q1,
		SBN_Q2,
		SBN_Q3,
		SBN_Q4
	} sbn_phase_t;
endpackage

// File: core/sbn_ram_if.sv
// Data memory port bundle between the datapath and its register file
`timescale 1ns/10ps
interface sbn_ram_if;
	import sbn_pkg::*;
	logic [SBN_ADDR_W-1:0] addr;
	logic [SBN_DATA_W-1:0] wdata;
	logic wr;
	logic [SBN_DATA_W-1:0] rdata;
	modport ctl (output addr, output wdata, output wr, input rdata);
	modport mem (input addr, input wdata, input wr, output rdata);
endinterface

// File: core/sbn_ram.sv
// Byte-wide data memory with registered read data
`timescale 1ns/10ps
module sbn_ram
	import sbn_pkg::*;
(
	input wire logic clk_i,
	sbn_ram_if.mem port
);
	logic [SBN_DATA_W-1:0] mem_q [2**SBN_ADDR_W];
	logic [SBN_DATA_W-1:0] rdata_q;

	// Plain always: the array has no reset, so a bench may preload it
	always @(posedge clk_i) begin
		if (port.wr) begin
			mem_q[port.addr] <= port.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		rdata_q <= mem_q[port.addr];
	end
	assign port.rdata = rdata_q;
endmodule

// File: core/sbn_alu.sv
// Four-phase datapath for subtract-with-borrow and nibble exchange
`timescale 1ns/10ps
module sbn_alu
	import sbn_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic INSTR_VALID_I,
	input wire logic [SBN_INSTR_W-1:0] INSTR_I,
	input wire logic [3:0] BANK_SEL_I,
	input wire logic EXT_SET_EN_I,
	input wire logic [SBN_ADDR_W-1:0] INDEX_BASE_I,
	output logic [SBN_DATA_W-1:0] ACC_O,
	output logic [4:0] FLAGS_O,
	output logic [1:0] PHASE_O,
	output logic DONE_O,
	output logic ILLEGAL_O
);
	sbn_ram_if ram ();
	sbn_ram u_ram (
		.clk_i(CLK_I),
		.port(ram.mem)
	);

	sbn_phase_t phase_q, phase_d;
	logic [SBN_INSTR_W-1:0] ir_q;
	logic [SBN_DATA_W-1:0] acc_q;
	logic [4:0] flags_q;
	logic [SBN_DATA_W-1:0] res_q;
	logic [4:0] res_flg_q;
	logic [SBN_ADDR_W-1:0] ea_q;
	logic busy_q;
	logic done_q;
	logic ill_q;

	function automatic logic [SBN_ADDR_W-1:0] eff_addr(
		input logic [7:0] f,
		input logic bank,
		input logic ext,
		input logic [3:0] bank_select_pointer,
		input logic [SBN_ADDR_W-1:0] idx
	);
		logic [SBN_ADDR_W-1:0] a;
		a = {bank_select_pointer, f};
		if (!bank) begin
			if (ext && f <= SBN_IDX_LIMIT) begin
				a = SBN_ADDR_W'(idx + {4'h0, f});
			end else if (f < SBN_ACC_SPLIT) begin
				a = {4'h0, f};
			end else begin
				a = {SBN_ACC_HI_BANK, f};
			end
		end
		return a;
	endfunction

	wire [5:0] opc = ir_q[15:10];
	wire is_subb = opc == SBN_OPC_SUBB;
	wire is_swap = opc == SBN_OPC_SWAP;
	wire dest_reg = ir_q[SBN_POS_DEST];
	wire [5:0] new_opc = INSTR_I[15:10];
	wire new_ok = new_opc == SBN_OPC_SUBB || new_opc == SBN_OPC_SWAP;
	wire [SBN_ADDR_W-1:0] ea_d = eff_addr(ir_q[7:0], ir_q[SBN_POS_BANK],
		EXT_SET_EN_I, BANK_SEL_I, INDEX_BASE_I);

	// Borrow is the inverted carry
	wire [SBN_DATA_W-1:0] opf = ram.rdata;
	wire borrow = ~flags_q[SBN_FLG_C];
	wire [8:0] diff = {1'b0, opf} - {1'b0, acc_q} - {8'h00, borrow};
	wire [4:0] ldiff = {1'b0, opf[3:0]} - {1'b0, acc_q[3:0]} - {4'h0, borrow};
	wire [7:0] sub_res = diff[7:0];
	wire sub_ov = (opf[7] ^ acc_q[7]) & (opf[7] ^ sub_res[7]);
	wire [4:0] sub_flg = {sub_res[7], sub_ov, sub_res == 8'h00,
		~ldiff[4], ~diff[8]};
	wire [7:0] swp_res = {opf[3:0], opf[7:4]};

	always_comb begin
		case (phase_q)
			SBN_Q1: phase_d = SBN_Q2;
			SBN_Q2: phase_d = SBN_Q3;
			SBN_Q3: phase_d = SBN_Q4;
			SBN_Q4: phase_d = SBN_Q1;
			default: phase_d = SBN_Q1;
		endcase
	end

	// Address held from Q2 so the Q4 write hits the byte read
	assign ram.addr = (phase_q == SBN_Q2) ? ea_d : ea_q;
	assign ram.wdata = res_q;
	assign ram.wr = busy_q && phase_q == SBN_Q4 && dest_reg &&
		(is_subb || is_swap);

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			phase_q <= SBN_Q1;
			ir_q <= '0;
			busy_q <= 1'b0;
			ea_q <= '0;
		end else begin
			phase_q <= phase_d;
			if (phase_q == SBN_Q1) begin
				ir_q <= INSTR_I;
				busy_q <= INSTR_VALID_I && new_ok;
			end
			if (phase_q == SBN_Q2) begin
				ea_q <= ea_d;
			end
		end
	end

	// Read data arrives one edge after Q2, so process at Q3
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			res_q <= '0;
			res_flg_q <= SBN_FLG_RST;
		end else if (phase_q == SBN_Q3) begin
			res_q <= is_subb ? sub_res : swp_res;
			res_flg_q <= is_subb ? sub_flg : flags_q;
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			acc_q <= SBN_ACC_RST;
			flags_q <= SBN_FLG_RST;
			done_q <= 1'b0;
			ill_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			ill_q <= 1'b0;
			if (phase_q == SBN_Q1) begin
				ill_q <= INSTR_VALID_I && !new_ok;
			end
			if (phase_q == SBN_Q4 && busy_q) begin
				if (!dest_reg) begin
					acc_q <= res_q;
				end
				flags_q <= res_flg_q;
				done_q <= 1'b1;
			end
		end
	end

	assign ACC_O = acc_q;
	assign FLAGS_O = flags_q;
	assign PHASE_O = phase_q;
	assign DONE_O = done_q;
	assign ILLEGAL_O = ill_q;
endmodule

// File: verif/sbn_alu_sva.sv
// Checker for phase order, completion, refusal and hold behaviour
`timescale 1ns/10ps
module sbn_alu_chk
	import sbn_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic INSTR_VALID_I,
	input wire logic [SBN_INSTR_W-1:0] INSTR_I,
	input wire logic [SBN_DATA_W-1:0] ACC_O,
	input wire logic [4:0] FLAGS_O,
	input wire logic [1:0] PHASE_O,
	input wire logic DONE_O,
	input wire logic ILLEGAL_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	wire logic tk = INSTR_VALID_I && PHASE_O == 2'h0;
	wire logic sb = tk && INSTR_I[15:10] == SBN_OPC_SUBB;
	wire logic sw = tk && INSTR_I[15:10] == SBN_OPC_SWAP;
	property p_done;
		(sb || sw) |-> ##[3:4] DONE_O;
	endproperty
	a_done: assert property (p_done) else $error("no completion");
	property p_dph;
		DONE_O |-> PHASE_O == 2'h0 && $past(PHASE_O) == 2'h3;
	endproperty
	a_dph: assert property (p_dph) else $error("done off phase");
	property p_seq;
		PHASE_O == 2'h1 |=> PHASE_O == 2'h2 ##1 PHASE_O == 2'h3;
	endproperty
	a_seq: assert property (p_seq) else $error("phase order");
	property p_swf;
		sw |=> $stable(FLAGS_O)[*4];
	endproperty
	a_swf: assert property (p_swf) else $error("flags moved");
	property p_d1;
		(sb || sw) && INSTR_I[SBN_POS_DEST] |=> $stable(ACC_O)[*4];
	endproperty
	a_d1: assert property (p_d1) else $error("acc moved");
	property p_ill;
		tk && !(sb || sw) |=> ILLEGAL_O && !DONE_O;
	endproperty
	a_ill: assert property (p_ill) else $error("bad word taken");
	c_sw: cover property (sw);
	c_sb: cover property (sb);
	c_ill: cover property (ILLEGAL_O);
endmodule
bind sbn_alu sbn_alu_chk chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I),
	.INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .ACC_O(ACC_O),
	.FLAGS_O(FLAGS_O), .PHASE_O(PHASE_O), .DONE_O(DONE_O),
	.ILLEGAL_O(ILLEGAL_O));

// File: verif/sbn_alu_tb_top.sv
// Self-checking bench for the datapath
`timescale 1ns/10ps
module sbn_alu_tb_top
	import sbn_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0, ext = 1'b0;
	logic [15:0] ins = 16'h0000;
	logic [3:0] bsel = 4'h0;
	logic [11:0] ibase = 12'h000;
	logic [7:0] acc;
	logic [4:0] flg;
	logic [1:0] ph;
	logic done, ill;
	int failures = 0, n_compared = 0, cyc = 0;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (++cyc == 3000) begin
			failures++;
			print_verdict();
		end
	end
	sbn_alu dut_u (.CLK_I(clk), .RESET_I(rst), .INSTR_VALID_I(vld),
		.INSTR_I(ins), .BANK_SEL_I(bsel), .EXT_SET_EN_I(ext),
		.INDEX_BASE_I(ibase), .ACC_O(acc), .FLAGS_O(flg), .PHASE_O(ph),
		.DONE_O(done), .ILLEGAL_O(ill));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Memory has no reset, so data tests preload known bytes
	task automatic poke(input logic [11:0] a, input logic [7:0] v);
		dut_u.u_ram.mem_q[a] = v;
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Word held through non-Q1 edges, which must ignore it
	task automatic op(input logic [15:0] w, input logic e);
		int n;
		@(posedge clk);
		vld <= 1'b1;
		ins <= w;
		bsel <= w[3:0] ^ 4'h5;
		ext <= w[0];
		ibase <= {4'h0, w[7:0]};
		n = 0;
		do @(negedge clk); while (ph !== 2'h0 && ++n < 8);
		@(negedge clk);
		chk({7'h00, ill}, {7'h00, e});
		@(posedge clk);
		vld <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, done}, {7'h00, !e});
	endtask
	// Memory powers up unknown and no opcode stores a known byte,
	// so data checks are limited to what must stay put
	task t_swap;
		for (int i = 0; i < 8; i++) begin
			op({SBN_OPC_SWAP, 1'b1, i[1], i[2] ? 8'h60 : 8'h5f}, 1'b0);
			chk(acc, 8'h00);
			chk({3'h0, flg}, 8'h00);
		end
		$display("swap done");
	endtask
	task t_ill;
		op(16'hffff, 1'b1);
		chk(acc, 8'h00);
		$display("refusal done");
	endtask
	task t_subb;
		for (int i = 0; i < 4; i++) begin
			op({SBN_OPC_SUBB, 1'b1, i[0], i[1] ? 8'h5f : 8'h60}, 1'b0);
			chk(acc, 8'h00);
		end
		$display("subtract done");
	endtask
	// Even f below 60h with bank bit 0 maps straight to bank 0
	task t_arith;
		poke(12'h010, 8'h01);
		poke(12'h020, 8'hd0);
		poke(12'h030, 8'h19);
		poke(12'h040, 8'he0);
		poke(12'h050, 8'h03);
		poke(12'h013, 8'h00);
		poke(12'h026, 8'ha7);
		poke(12'hf62, 8'h4b);
		poke(12'h062, 8'h00);
		poke(12'h124, 8'h96);
		poke(12'h024, 8'h00);
		op({SBN_OPC_SUBB, 2'b00, 8'h10}, 1'b0);
		chk(acc, 8'h00);
		chk({3'h0, flg}, 8'h07);
		op({SBN_OPC_SWAP, 2'b00, 8'h20}, 1'b0);
		chk(acc, 8'h0d);
		chk({3'h0, flg}, 8'h07);
		op({SBN_OPC_SUBB, 2'b00, 8'h30}, 1'b0);
		chk(acc, 8'h0c);
		chk({3'h0, flg}, 8'h01);
		op({SBN_OPC_SWAP, 2'b00, 8'h40}, 1'b0);
		chk(acc, 8'h0e);
		op({SBN_OPC_SUBB, 2'b10, 8'h50}, 1'b0);
		chk(acc, 8'h0e);
		chk({3'h0, flg}, 8'h10);
		op({SBN_OPC_SWAP, 2'b00, 8'h50}, 1'b0);
		chk(acc, 8'h5f);
		chk({3'h0, flg}, 8'h10);
		op({SBN_OPC_SWAP, 2'b00, 8'h13}, 1'b0);
		chk(acc, 8'h7a);
		op({SBN_OPC_SWAP, 2'b00, 8'h62}, 1'b0);
		chk(acc, 8'hb4);
		op({SBN_OPC_SWAP, 2'b01, 8'h24}, 1'b0);
		chk(acc, 8'h69);
		$display("arithmetic done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({6'h00, ph}, 8'h00);
		t_swap();
		t_ill();
		t_subb();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(acc, 8'h00);
		chk({3'h0, flg}, 8'h00);
		chk({6'h00, ph}, 8'h00);
		t_arith();
		print_verdict();
	end
endmodule
